// ===== verilog/gcd_datapath.v
// gcd_datapath: graphics-controller registers and four-plane read/write datapath
// assumes single-cycle host strobes, memory returns plane bytes combinationally
`timescale 1ns/1ps
`include "gcd_regs.vh"
module gcd_datapath #(
    parameter INDEX_WIDTH = 4
) (
    input wire clk_sys,
    input wire rst_n,
    input wire io_index_wr,
    input wire io_data_wr,
    input wire io_data_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata_q,
    input wire chain_four,
    input wire mem_wr,
    input wire mem_rd,
    input wire [19:0] host_addr,
    input wire [7:0] host_wdata,
    output reg [7:0] host_rdata_q,
    output reg host_hit_q,
    input wire [31:0] plane_rdata,
    output reg plane_we_q,
    output reg [3:0] plane_sel_q,
    output reg [15:0] plane_addr_q,
    output reg [31:0] plane_wdata_q,
    output reg [1:0] shift_format_q,
    output reg graphics_mode_q,
    output reg [3:0] read_plane_q
);
    reg [INDEX_WIDTH-1:0] index_q;
    reg [3:0] fill_value_q;
    reg [3:0] fill_enable_q;
    reg [3:0] compare_colour_q;
    reg [7:0] rotate_and_logic_op_q;
    reg [1:0] read_plane_select_q;
    reg [7:0] read_write_mode_control_q;
    reg [7:0] memory_window_and_chain_q;
    reg [3:0] compare_plane_mask_q;
    reg [7:0] pixel_write_mask_q;
    reg [31:0] latch_q;
    wire hit;
    wire [15:0] offset;
    wire [31:0] alu_out;
    wire [7:0] rotated;
    wire [2:0] rotate_count;
    wire [1:0] logic_op_select;
    wire [1:0] write_mode_select;
    wire read_mode_select;
    wire odd_even_split;
    wire chain_odd_even;
    reg [7:0] reg_rd;
    reg [3:0] wr_planes;
    reg [1:0] rd_plane;
    reg [15:0] mem_addr;
    reg [7:0] cmp;
    integer k;

    assign rotate_count = rotate_and_logic_op_q[`GCD_ROT_MSB:`GCD_ROT_LSB];
    assign logic_op_select = rotate_and_logic_op_q[`GCD_LOP_MSB:`GCD_LOP_LSB];
    assign write_mode_select = read_write_mode_control_q[`GCD_WM_MSB:`GCD_WM_LSB];
    assign read_mode_select = read_write_mode_control_q[`GCD_RM_BIT];
    assign odd_even_split = read_write_mode_control_q[`GCD_OE_BIT]; // RULE_06
    assign chain_odd_even = memory_window_and_chain_q[`GCD_COE_BIT];

    // -------------------------------------------
    // helpers
    // -------------------------------------------
    function [7:0] rotr;
        input [7:0] d;
        input [2:0] n;
        reg [15:0] t;
        begin
            t = {d, d} >> n;
            rotr = t[7:0];
        end
    endfunction

    function [7:0] plane_byte;
        input [31:0] p;
        input [1:0] n;
        begin
            plane_byte = p[n*8 +: 8];
        end
    endfunction

    assign rotated = rotr(host_wdata, rotate_count); // RULE_02

    gcd_window_decode u_window (
        .memory_window_select(memory_window_and_chain_q[`GCD_MW_MSB:`GCD_MW_LSB]),
        .host_addr(host_addr),
        .hit(hit),
        .offset(offset)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_plane
            gcd_plane_alu u_alu (
                .write_mode_select(write_mode_select),
                .logic_op_select(logic_op_select),
                .rotated(rotated),
                .host_data(host_wdata),
                .latch(latch_q[g*8 +: 8]),
                .fill_value_bit(fill_value_q[g]),
                .fill_enable_bit(fill_enable_q[g]),
                .pixel_write_mask(pixel_write_mask_q),
                .plane_index(g[1:0]),
                .result(alu_out[g*8 +: 8])
            );
        end
    endgenerate

    // -------------------------------------------
    // addressing and plane selection
    // -------------------------------------------
    always @* begin
        mem_addr = offset;
        wr_planes = 4'hf;
        if (chain_odd_even) begin
            mem_addr = {offset[15:1], offset[15]}; // RULE_18
            wr_planes = offset[0] ? 4'ha : 4'h5; // RULE_18
        end else if (odd_even_split) begin
            wr_planes = offset[0] ? 4'ha : 4'h5; // RULE_05
        end else if (chain_four) begin
            wr_planes = 4'h1 << offset[1:0];
            mem_addr = {2'b00, offset[15:2]};
        end
        if (chain_four) begin
            rd_plane = offset[1:0]; // RULE_07
        end else if (odd_even_split || chain_odd_even) begin
            rd_plane = {read_plane_select_q[1], offset[0]}; // RULE_05
        end else begin
            rd_plane = read_plane_select_q; // RULE_03
        end
    end

    // -------------------------------------------
    // colour compare
    // -------------------------------------------
    always @* begin
        for (k = 0; k < 8; k = k + 1) begin
            // masked planes always match, so a zero mask reads all ones
            cmp[k] = &(~((plane_rdata[24+k] ^ compare_colour_q[3]) & compare_plane_mask_q[3])
                    & ~((plane_rdata[16+k] ^ compare_colour_q[2]) & compare_plane_mask_q[2])
                    & ~((plane_rdata[8+k] ^ compare_colour_q[1]) & compare_plane_mask_q[1])
                    & ~((plane_rdata[k] ^ compare_colour_q[0]) & compare_plane_mask_q[0])); // RULE_09 RULE_10
        end
    end

    // -------------------------------------------
    // register readback
    // -------------------------------------------
    always @* begin
        case (index_q) // RULE_20
            `GCD_IDX_FILL_VALUE: reg_rd = {4'h0, fill_value_q};
            `GCD_IDX_FILL_ENABLE: reg_rd = {4'h0, fill_enable_q};
            `GCD_IDX_COMPARE_COLOUR: reg_rd = {4'h0, compare_colour_q};
            `GCD_IDX_ROTATE_LOGIC: reg_rd = {3'h0, rotate_and_logic_op_q[4:0]};
            `GCD_IDX_READ_PLANE: reg_rd = {6'h00, read_plane_select_q};
            `GCD_IDX_MODE: reg_rd = {1'b0, read_write_mode_control_q[6:3], 1'b0,
                                     read_write_mode_control_q[1:0]};
            `GCD_IDX_WINDOW: reg_rd = {4'h0, memory_window_and_chain_q[3:0]};
            `GCD_IDX_COMPARE_MASK: reg_rd = {4'h0, compare_plane_mask_q};
            `GCD_IDX_PIXEL_MASK: reg_rd = pixel_write_mask_q;
            default: reg_rd = 8'h00;
        endcase
    end

    // -------------------------------------------
    // registers
    // -------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            index_q <= {INDEX_WIDTH{1'b0}};
            fill_value_q <= 4'h0;
            fill_enable_q <= 4'h0;
            compare_colour_q <= 4'h0;
            rotate_and_logic_op_q <= `GCD_RST_REG;
            read_plane_select_q <= 2'b00;
            read_write_mode_control_q <= `GCD_RST_REG;
            memory_window_and_chain_q <= `GCD_RST_REG;
            compare_plane_mask_q <= 4'h0;
            pixel_write_mask_q <= `GCD_RST_PIXEL_MASK;
            io_rdata_q <= 8'h00;
        end else begin
            if (io_index_wr) begin
                index_q <= io_wdata[INDEX_WIDTH-1:0]; // RULE_20
            end
            if (io_data_rd) begin
                io_rdata_q <= reg_rd;
            end
            if (io_data_wr) begin
                case (index_q) // RULE_20
                    `GCD_IDX_FILL_VALUE: fill_value_q <= io_wdata[3:0];
                    `GCD_IDX_FILL_ENABLE: fill_enable_q <= io_wdata[3:0];
                    `GCD_IDX_COMPARE_COLOUR: compare_colour_q <= io_wdata[3:0];
                    `GCD_IDX_ROTATE_LOGIC: rotate_and_logic_op_q <= {3'h0, io_wdata[4:0]};
                    `GCD_IDX_READ_PLANE: read_plane_select_q <= io_wdata[1:0];
                    `GCD_IDX_MODE: read_write_mode_control_q <= {1'b0, io_wdata[6:3], 1'b0, io_wdata[1:0]};
                    `GCD_IDX_WINDOW: memory_window_and_chain_q <= {4'h0, io_wdata[3:0]};
                    `GCD_IDX_COMPARE_MASK: compare_plane_mask_q <= io_wdata[3:0];
                    `GCD_IDX_PIXEL_MASK: pixel_write_mask_q <= io_wdata;
                    default: begin
                    end
                endcase
            end
        end
    end

    // -------------------------------------------
    // memory cycles
    // -------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= 32'h00000000;
            host_rdata_q <= 8'h00;
            host_hit_q <= 1'b0;
            plane_we_q <= 1'b0;
            plane_sel_q <= 4'h0;
            plane_addr_q <= 16'h0000;
            plane_wdata_q <= 32'h00000000;
        end else begin
            host_hit_q <= hit & (mem_rd | mem_wr);
            plane_we_q <= hit & mem_wr;
            if (hit & (mem_rd | mem_wr)) begin
                plane_addr_q <= mem_addr;
            end
            if (hit & mem_wr) begin
                // write mode 1 ignores the split and writes all planes
                plane_sel_q <= (write_mode_select == 2'b01) ? 4'hf : wr_planes; // RULE_13
                plane_wdata_q <= alu_out;
            end
            if (hit & mem_rd) begin
                latch_q <= plane_rdata; // RULE_21
                if (read_mode_select) begin
                    host_rdata_q <= cmp; // RULE_08
                end else begin
                    host_rdata_q <= plane_byte(plane_rdata, rd_plane); // RULE_07
                end
            end
        end
    end

    // -------------------------------------------
    // status outputs
    // -------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_format_q <= 2'b00;
            graphics_mode_q <= 1'b0;
            read_plane_q <= 4'h0;
        end else begin
            shift_format_q <= read_write_mode_control_q[`GCD_SF_MSB:`GCD_SF_LSB]; // RULE_04
            graphics_mode_q <= memory_window_and_chain_q[`GCD_GFX_BIT]; // RULE_19
            read_plane_q <= 4'h1 << rd_plane;
        end
    end
endmodule // gcd_datapath

// ===== verilog/gcd_regs.vh
// graphics-controller datapath constants: register indices, field positions, reset values
// assumes inclusion by every gcd design file; definitions only
//
// Notes on behaviour
// [RULE_01] logic op 00 pass, 01 and, 10 or, 11 xor with latched plane data
// [RULE_02] host data rotated right by rotate count before the logic op
// [RULE_03] read plane select chooses the plane returned on host reads
// [RULE_04] shift format: 00 per-plane serial, 01 four-colour packed, 1x eight bits at once
// [RULE_05] odd/even split: even addresses reach planes 0 and 2, odd reach 1 and 3
// [RULE_06] software keeps the split bit the complement of the sequencer odd/even bit
// [RULE_07] read mode 0 returns selected plane, or plane from low address bits when chained
// [RULE_08] read mode 1 returns per-pixel colour compare result of four planes
// [RULE_09] compare colour bit n is matched against plane n
// [RULE_10] compare plane mask 0 drops a plane from the compare, used only in read mode 1
// [RULE_11] write mode 0: rotated data, or fill value for planes with fill enabled
// [RULE_12] fill enable bit n picks fill value bit n as plane n write source
// [RULE_13] write mode 1 copies latched data of all four planes to the address
// [RULE_14] write mode 2 fills plane n with eight copies of host data bit n
// [RULE_15] write mode 3: fill value always, rotated data and pixel mask form the mask
// [RULE_16] pixel write mask bit 0 keeps that pixel unchanged in every plane
// [RULE_17] memory window 00/01 a0000-affff, 10 b0000-b0fff, 11 b8000-bffff
// [RULE_18] chain odd/even replaces address bit 0 with a higher bit, bit 0 picks plane pair
// [RULE_19] graphics select bit 0 alphanumeric, 1 graphics
// [RULE_20] index port selects the register reached through the data port
// [RULE_21] every display memory read loads the four plane latches
`ifndef GCD_REGS_VH
`define GCD_REGS_VH
`define GCD_IDX_FILL_VALUE 4'h0
`define GCD_IDX_FILL_ENABLE 4'h1
`define GCD_IDX_COMPARE_COLOUR 4'h2
`define GCD_IDX_ROTATE_LOGIC 4'h3
`define GCD_IDX_READ_PLANE 4'h4
`define GCD_IDX_MODE 4'h5
`define GCD_IDX_WINDOW 4'h6
`define GCD_IDX_COMPARE_MASK 4'h7
`define GCD_IDX_PIXEL_MASK 4'h8
`define GCD_ROT_LSB 0
`define GCD_ROT_MSB 2
`define GCD_LOP_LSB 3
`define GCD_LOP_MSB 4
`define GCD_WM_LSB 0
`define GCD_WM_MSB 1
`define GCD_RM_BIT 3
`define GCD_OE_BIT 4
`define GCD_SF_LSB 5
`define GCD_SF_MSB 6
`define GCD_GFX_BIT 0
`define GCD_COE_BIT 1
`define GCD_MW_LSB 2
`define GCD_MW_MSB 3
`define GCD_RST_REG 8'h00
`define GCD_RST_PIXEL_MASK 8'hff
`define GCD_WIN_A_BASE 20'ha0000
`define GCD_WIN_A_LAST 20'haffff
`define GCD_WIN_B_BASE 20'hb0000
`define GCD_WIN_B_LAST 20'hb0fff
`define GCD_WIN_C_BASE 20'hb8000
`define GCD_WIN_C_LAST 20'hbffff
`endif

// ===== verilog/gcd_window_decode.v
// gcd_window_decode: host memory window hit and offset
// assumes a 20-bit real-mode host address, combinational use
`timescale 1ns/1ps
`include "gcd_regs.vh"
module gcd_window_decode (
    input wire [1:0] memory_window_select,
    input wire [19:0] host_addr,
    output reg hit,
    output reg [15:0] offset
);
    // -------------------------------------------
    // window compare
    // -------------------------------------------
    always @* begin
        hit = 1'b0;
        offset = 16'h0000;
        case (memory_window_select) // RULE_17
            2'b00, 2'b01: begin
                hit = (host_addr >= `GCD_WIN_A_BASE) && (host_addr <= `GCD_WIN_A_LAST);
                offset = host_addr[15:0];
            end
            2'b10: begin
                hit = (host_addr >= `GCD_WIN_B_BASE) && (host_addr <= `GCD_WIN_B_LAST);
                offset = {4'h0, host_addr[11:0]};
            end
            2'b11: begin
                hit = (host_addr >= `GCD_WIN_C_BASE) && (host_addr <= `GCD_WIN_C_LAST);
                offset = {1'b0, host_addr[14:0]};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end
endmodule // gcd_window_decode

// ===== verilog/gcd_plane_alu.v
// gcd_plane_alu: per-plane write data path for one display plane
// assumes rotated host data and latches arrive from the top
`timescale 1ns/1ps
`include "gcd_regs.vh"
module gcd_plane_alu (
    input wire [1:0] write_mode_select,
    input wire [1:0] logic_op_select,
    input wire [7:0] rotated,
    input wire [7:0] host_data,
    input wire [7:0] latch,
    input wire fill_value_bit,
    input wire fill_enable_bit,
    input wire [7:0] pixel_write_mask,
    input wire [1:0] plane_index,
    output reg [7:0] result
);
    reg [7:0] src;
    reg [7:0] op;
    reg [7:0] mask;
    // -------------------------------------------
    // source, logic op, mask
    // -------------------------------------------
    always @* begin
        src = rotated;
        mask = pixel_write_mask; // RULE_16
        case (write_mode_select)
            2'b00: src = fill_enable_bit ? {8{fill_value_bit}} : rotated; // RULE_11 RULE_12
            2'b10: src = {8{host_data[plane_index]}}; // RULE_14
            2'b11: begin
                src = {8{fill_value_bit}}; // RULE_15
                mask = rotated & pixel_write_mask; // RULE_15
            end
            default: src = rotated;
        endcase
        case (logic_op_select) // RULE_01
            2'b01: op = src & latch;
            2'b10: op = src | latch;
            2'b11: op = src ^ latch;
            default: op = src;
        endcase
        if (write_mode_select == 2'b01) begin
            result = latch; // RULE_13
        end else begin
            result = (op & mask) | (latch & ~mask); // RULE_16
        end
    end
endmodule // gcd_plane_alu

// ===== test/gcd_datapath_properties.sv
// checker: port-level assertions for the graphics-controller datapath
// assumes one clock domain and a bind onto every gcd_datapath instance
`timescale 1ns/1ps
module gcd_datapath_properties (
    input wire clk_sys,
    input wire rst_n,
    input wire io_index_wr,
    input wire io_data_wr,
    input wire io_data_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata_q,
    input wire mem_wr,
    input wire mem_rd,
    input wire [19:0] host_addr,
    input wire [7:0] host_rdata_q,
    input wire host_hit_q,
    input wire plane_we_q,
    input wire [1:0] shift_format_q,
    input wire graphics_mode_q,
    input wire [3:0] read_plane_q
);
    // ----
    // shadow of index, mode and window registers
    // ----
    reg [3:0] idx_q;
    reg [7:0] mode_q;
    reg [7:0] misc_q;
    wire hit_w;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= 4'h0;
            mode_q <= 8'h00;
            misc_q <= 8'h00;
        end else begin
            if (io_index_wr) idx_q <= io_wdata[3:0];
            if (io_data_wr && idx_q == 4'h5) mode_q <= io_wdata;
            if (io_data_wr && idx_q == 4'h6) misc_q <= io_wdata;
        end
    end
    assign hit_w = !misc_q[3] ? host_addr[19:16] == 4'ha :
        !misc_q[2] ? host_addr[19:12] == 8'hb0 : host_addr[19:15] == 5'h17;
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence wr_hit_s;
        mem_wr && hit_w;
    endsequence
    sequence wr_alone_s;
        wr_hit_s ##1 !mem_wr;
    endsequence
    we_pulse_a: assert property (wr_alone_s |-> plane_we_q ##1 !plane_we_q)
        else $error("plane write is not a single pulse");
    we_track_a: assert property ($past(rst_n) |-> plane_we_q == $past(mem_wr && hit_w))
        else $error("plane write does not follow a window hit");
    hit_track_a: assert property ($past(rst_n) |-> host_hit_q == $past((mem_wr || mem_rd) && hit_w))
        else $error("hit flag does not match window decode");
    rdata_hold_a: assert property (!mem_rd |=> $stable(host_rdata_q))
        else $error("memory read data changed without a read");
    io_hold_a: assert property (!io_data_rd |=> $stable(io_rdata_q))
        else $error("register read data changed without a read");
    read_onehot_a: assert property ($past(rst_n) |-> $onehot(read_plane_q))
        else $error("read plane is not one-hot");
    shift_follow_a: assert property ($past(rst_n) |-> shift_format_q == $past(mode_q[6:5]))
        else $error("shift format does not follow mode register");
    gfx_follow_a: assert property ($past(rst_n) |-> graphics_mode_q == $past(misc_q[0]))
        else $error("graphics mode does not follow window register");
endmodule // gcd_datapath_properties

bind gcd_datapath gcd_datapath_properties i_gcd_datapath_properties (.clk_sys, .rst_n, .io_index_wr,
    .io_data_wr, .io_data_rd, .io_wdata, .io_rdata_q, .mem_wr, .mem_rd, .host_addr, .host_rdata_q,
    .host_hit_q, .plane_we_q, .shift_format_q, .graphics_mode_q, .read_plane_q);

// ===== test/gcd_plane_mem.sv
// display memory model: four planes of 256 bytes
// assumes plane writes on plane_we_q, reads follow host_addr at once
`timescale 1ns/1ps
module gcd_plane_mem (
    input wire clk_sys,
    input wire [19:0] host_addr,
    input wire plane_we_q,
    input wire [3:0] plane_sel_q,
    input wire [15:0] plane_addr_q,
    input wire [31:0] plane_wdata_q,
    output wire [31:0] plane_rdata
);
    reg [7:0] mem [0:3][0:255];
    integer p;
    integer q;
    integer r;
    // zeroed so stray reads never carry unknowns into the latches
    initial begin
        for (q = 0; q < 4; q = q + 1) begin
            for (r = 0; r < 256; r = r + 1) begin
                mem[q][r] = 8'h00;
            end
        end
    end
    // raw byte per plane at host_addr[7:0]; reads bypass the datapath swizzling, only writes use plane_addr_q
    assign plane_rdata = {mem[3][host_addr[7:0]], mem[2][host_addr[7:0]], mem[1][host_addr[7:0]],
        mem[0][host_addr[7:0]]};
    always @(posedge clk_sys) begin
        for (p = 0; p < 4; p = p + 1) begin
            if (plane_we_q && plane_sel_q[p]) mem[p][plane_addr_q[7:0]] <= plane_wdata_q[p*8 +: 8];
        end
    end
endmodule // gcd_plane_mem

// ===== test/tb.sv
// testbench: register, read, write and address scenarios for the datapath
// assumes the plane memory model and the bound checker
`timescale 1ns/1ps
// case equality so an unknown never passes
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg io_index_wr = 1'b0;
    reg io_data_wr = 1'b0;
    reg io_data_rd = 1'b0;
    reg [7:0] io_wdata = 8'h00;
    reg chain_four = 1'b0;
    reg mem_wr = 1'b0;
    reg mem_rd = 1'b0;
    reg [19:0] host_addr = 20'h00000;
    reg [7:0] host_wdata = 8'h00;
    wire [7:0] io_rdata_q;
    wire [7:0] host_rdata_q;
    wire host_hit_q;
    wire [31:0] plane_rdata;
    wire plane_we_q;
    wire [3:0] plane_sel_q;
    wire [15:0] plane_addr_q;
    wire [31:0] plane_wdata_q;
    wire [1:0] shift_format_q;
    wire graphics_mode_q;
    wire [3:0] read_plane_q;
    reg [31:0] pre;
    reg [31:0] ew;
    integer n_fail = 0;
    integer n_checks = 0;
    localparam [79:0] RMASK = 80'h00ff0f0f7b031f0f0f0f;
    localparam [215:0] WIN = 216'h1a0000_1affff_09ffff_4b0000_5a8000_9b0fff_8b1000_db8000_ca0000;
    gcd_datapath i_gcd_datapath (.clk_sys, .rst_n, .io_index_wr, .io_data_wr, .io_data_rd, .io_wdata,
        .io_rdata_q, .chain_four, .mem_wr, .mem_rd, .host_addr, .host_wdata, .host_rdata_q, .host_hit_q,
        .plane_rdata, .plane_we_q, .plane_sel_q, .plane_addr_q, .plane_wdata_q, .shift_format_q,
        .graphics_mode_q, .read_plane_q);
    gcd_plane_mem i_gcd_plane_mem (.clk_sys, .host_addr, .plane_we_q, .plane_sel_q, .plane_addr_q,
        .plane_wdata_q, .plane_rdata);
    always #25 clk_sys = ~clk_sys;
    // ----
    // bus tasks and expectations
    // ----
    task io_acc(input [3:0] i, input [7:0] v, input rd);
        begin
            @(posedge clk_sys);
            io_index_wr <= 1'b1;
            io_wdata <= {4'h0, i};
            @(posedge clk_sys);
            io_index_wr <= 1'b0;
            io_data_wr <= !rd;
            io_data_rd <= rd;
            io_wdata <= v;
            @(posedge clk_sys);
            io_data_wr <= 1'b0;
            io_data_rd <= 1'b0;
            @(negedge clk_sys);
        end
    endtask
    task mem_acc(input [19:0] a, input [7:0] d, input rd);
        begin
            @(posedge clk_sys);
            mem_wr <= !rd;
            mem_rd <= rd;
            host_addr <= a;
            host_wdata <= d;
            @(posedge clk_sys);
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            @(negedge clk_sys);
        end
    endtask
    function [31:0] wexp(input [1:0] wm, input [1:0] lop, input [2:0] rot, input [7:0] d,
        input [31:0] lat, input [3:0] fv, input [3:0] fe, input [7:0] pm);
        reg [7:0] r;
        reg [7:0] s;
        reg [7:0] m;
        reg [7:0] l;
        integer p;
        begin
            r = (d >> rot) | (d << (8 - rot));
            m = (wm == 2'h3) ? (r & pm) : pm;
            for (p = 0; p < 4; p = p + 1) begin
                l = lat[p*8 +: 8];
                s = (wm == 2'h2) ? {8{d[p]}} : (wm == 2'h3 || fe[p]) ? {8{fv[p]}} : r;
                case (lop)
                    2'h1: s = s & l;
                    2'h2: s = s | l;
                    2'h3: s = s ^ l;
                    default: s = s;
                endcase
                wexp[p*8 +: 8] = (wm == 2'h1) ? l : (s & m) | (l & ~m);
            end
        end
    endfunction
    function [7:0] cexp(input [31:0] pl, input [3:0] c, input [3:0] k);
        integer p;
        begin
            cexp = 8'hff;
            for (p = 0; p < 4; p = p + 1) begin
                if (k[p]) cexp = cexp & ~(pl[p*8 +: 8] ^ {8{c[p]}});
            end
        end
    endfunction
    // ----
    // scenarios
    // ----
    task t_regs;
        integer i;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                io_acc(i[3:0], 8'h00, 1'b1);
                `CHK(io_rdata_q, (i == 8) ? 8'hff : 8'h00)
                io_acc(i[3:0], 8'hff, 1'b0);
                io_acc(i[3:0], 8'h00, 1'b1);
                `CHK(io_rdata_q, RMASK[i*8 +: 8])
                io_acc(i[3:0], (i == 8) ? 8'hff : 8'h00, 1'b0);
            end
        end
    endtask
    task t_read;
        integer i;
        integer j;
        reg [3:0] k;
        begin
            pre = 32'hc35af00f;
            for (i = 0; i < 16; i = i + 1) begin
                i_gcd_plane_mem.mem[i % 4][8'h10 + i / 4] = pre[(i % 4)*8 +: 8];
            end
            for (i = 0; i < 4; i = i + 1) begin
                io_acc(4'h4, i[7:0], 1'b0);
                mem_acc(20'ha0010, 8'h00, 1'b1);
                `CHK(host_rdata_q, pre[i*8 +: 8])
                `CHK(read_plane_q, 4'h1 << i)
            end
            @(posedge clk_sys);
            chain_four <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                mem_acc(20'ha0010 + i[19:0], 8'h00, 1'b1);
                `CHK(host_rdata_q, pre[i*8 +: 8])
            end
            chain_four <= 1'b0;
            io_acc(4'h5, 8'h08, 1'b0);
            for (j = 0; j < 32; j = j + 1) begin
                k = j[4] ? ~j[3:0] : 4'hf;
                io_acc(4'h2, {4'h0, j[3:0]}, 1'b0);
                io_acc(4'h7, {4'h0, k}, 1'b0);
                mem_acc(20'ha0010, 8'h00, 1'b1);
                `CHK(host_rdata_q, cexp(pre, j[3:0], k))
            end
            io_acc(4'h5, 8'h00, 1'b0);
        end
    endtask
    task t_write;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                io_acc(4'h3, {3'h0, i[1:0], i[2:0] + 3'h1}, 1'b0);
                io_acc(4'h8, 8'h3c << i, 1'b0);
                mem_acc(20'ha0020, 8'h96, 1'b0);
                ew = wexp(2'h0, i[1:0], i[2:0] + 3'h1, 8'h96, pre, 4'h0, 4'h0, 8'h3c << i);
                `CHK(plane_wdata_q, ew)
            end
            io_acc(4'h3, 8'h00, 1'b0);
            io_acc(4'h0, 8'h04, 1'b0);
            io_acc(4'h1, 8'h05, 1'b0);
            for (i = 0; i < 4; i = i + 1) begin
                io_acc(4'h5, i[7:0], 1'b0);
                io_acc(4'h3, (i == 3) ? 8'h02 : 8'h00, 1'b0);
                mem_acc(20'ha0020, 8'hb6, 1'b0);
                ew = wexp(i[1:0], 2'h0, (i == 3) ? 3'h2 : 3'h0, 8'hb6, pre, 4'h4, 4'h5, 8'he0);
                `CHK(plane_wdata_q, ew)
                `CHK(plane_sel_q, 4'hf)
            end
            io_acc(4'h5, 8'h00, 1'b0);
            io_acc(4'h3, 8'h00, 1'b0);
        end
    endtask
    task t_addr;
        integer i;
        begin
            for (i = 0; i < 9; i = i + 1) begin
                io_acc(4'h6, {4'h0, WIN[i*24 + 22 +: 2], 2'h0}, 1'b0);
                mem_acc(WIN[i*24 +: 20], 8'h00, 1'b1);
                `CHK(host_hit_q, WIN[i*24 + 20])
            end
            io_acc(4'h6, 8'h00, 1'b0);
            mem_acc(20'h90010, 8'h11, 1'b0);
            `CHK(plane_we_q, 1'b0)
            // sequencer odd/even bit assumed clear, so the split bit is set
            io_acc(4'h5, 8'h10, 1'b0);
            for (i = 0; i < 2; i = i + 1) begin
                mem_acc(20'ha0010 + i[19:0], 8'h22, 1'b0);
                `CHK(plane_sel_q, i[0] ? 4'ha : 4'h5)
            end
            io_acc(4'h5, 8'h00, 1'b0);
            io_acc(4'h6, 8'h02, 1'b0);
            for (i = 0; i < 4; i = i + 1) begin
                mem_acc(20'ha0010 | {4'h0, i[1], 14'h0, i[0]}, 8'h33, 1'b0);
                `CHK(plane_sel_q, i[0] ? 4'ha : 4'h5)
                `CHK(plane_addr_q, {i[1], 14'h0008, i[1]})
            end
            for (i = 0; i < 4; i = i + 1) begin
                io_acc(4'h5, {1'b0, i[1:0], 5'h00}, 1'b0);
                io_acc(4'h6, {7'h00, i[0]}, 1'b0);
                @(negedge clk_sys);
                `CHK(shift_format_q, i[1:0])
                `CHK(graphics_mode_q, i[0])
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // whole run is well under a thousand cycles; this leaves ample margin
    initial begin
        #2000000;
        $display("Error t=%0t watchdog expired", $time);
        n_fail = n_fail + 1;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs;
        t_read;
        t_write;
        t_addr;
        wrap_up;
    end
endmodule // tb
